//--- core/pmcc_pkg.sv
// constants, register map and mode encoding for the power mode clock control
package pmcc_pkg;

    // ==================================================
    // register map (byte addresses)
    localparam logic [3:0] PMCC_PLL_CONTROL_REG_OFS = 4'h0;
    localparam logic [3:0] PMCC_PERIPH_EN_OFS = 4'h4;
    localparam logic [3:0] PMCC_STATUS_OFS = 4'h8;

    // ==================================================
    // pll control register fields
    localparam int PMCC_MSEL_LSB = 0;
    localparam int PMCC_MSEL_W = 5;
    localparam int PMCC_DF_BIT = 5;
    localparam int PMCC_BYPASS_BIT = 6;
    localparam int PMCC_SSEL_LSB = 8;
    localparam int PMCC_SSEL_W = 2;
    localparam int PMCC_GO_BIT = 12;
    localparam int PMCC_SLEEP_BIT = 13;
    localparam int PMCC_DEEP_BIT = 14;

    // ==================================================
    // peripheral clock enable register
    localparam int PMCC_NUM_PERIPH = 14;
    localparam logic [13:0] PMCC_PERIPH_EN_RST = 14'h3FFF;

    // ==================================================
    // multiplier range and divide codes
    localparam logic [4:0] PMCC_MSEL_MIN = 5'h01;
    localparam logic [4:0] PMCC_MSEL_MAX = 5'h1F;
    localparam logic [1:0] PMCC_SSEL_2 = 2'h0;
    localparam logic [1:0] PMCC_SSEL_2P5 = 2'h1;
    localparam logic [1:0] PMCC_SSEL_3 = 2'h2;
    localparam logic [1:0] PMCC_SSEL_4 = 2'h3;

    // ==================================================
    // operating modes
    typedef enum logic [1:0] {
        PMCC_FULL_ON = 2'b00,
        PMCC_ACTIVE = 2'b01,
        PMCC_SLEEP = 2'b10,
        PMCC_DEEP_SLEEP = 2'b11
    } pmcc_mode_e;

endpackage

//--- core/pmcc_half_div.sv
// divide-by-two enable for the bypassed core clock
module pmcc_half_div
    import pmcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    // enable out
    output logic tick_o
);

    logic phase_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    assign tick_o = run_i & phase_q;

endmodule

//--- core/pmcc_sclk_div.sv
// fractional system clock divider driven by core clock enables
module pmcc_sclk_div
    import pmcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic core_clock_tick_i,
    input wire logic run_i,
    input wire logic [1:0] ssel_i,
    // enable out
    output logic sclk_tick_o
);

    // counts half core ticks so that 2.5 can be made as 5 half ticks
    logic [2:0] cnt_q;
    logic [2:0] limit;
    logic [3:0] sum;
    logic wrap;

    always_comb begin
        unique case (ssel_i)
            PMCC_SSEL_2: limit = 3'h3;
            PMCC_SSEL_2P5: limit = 3'h4;
            PMCC_SSEL_3: limit = 3'h5;
            PMCC_SSEL_4: limit = 3'h7;
        endcase
    end

    // one bit wider than the count so that 6 + 2 does not fold to zero
    assign sum = {1'b0, cnt_q} + 4'h2;
    assign wrap = sum > {1'b0, limit};

    // 2.5:1 alternates two and three core ticks per system tick
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= 3'h0;
        end else if (core_clock_tick_i) begin
            if (wrap) begin
                cnt_q <= 3'(sum - ({1'b0, limit} + 4'h1));
            end else begin
                cnt_q <= sum[2:0];
            end
        end
    end

    assign sclk_tick_o = run_i & core_clock_tick_i & wrap;

endmodule

//--- core/pmcc_top.sv
// operating mode controller with core and system clock enable generation
module pmcc_top
    import pmcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // strap pins
    input wire logic [4:0] multiplier_select_straps_i,
    input wire logic bypass_strap_i,
    input wire logic input_divide_strap_i,
    input wire logic [1:0] ssel_straps_i,
    // events
    input wire logic irq_any_i,
    input wire logic rtc_irq_i,
    input wire logic reset_irq_i,
    input wire logic core_idle_i,
    // clock enables and status
    output logic core_clock_en_o,
    output logic system_clock_output_pin_o,
    output logic [13:0] periph_clk_en_o,
    output logic pll_enable_o,
    output logic pll_bypass_o,
    output logic [4:0] pll_mult_o,
    output logic pll_input_div_o,
    output logic dma_l1_allow_o,
    output logic deep_sleep_indicator_o,
    output logic [1:0] mode_o
);

    // ==================================================
    // pin synchronisers
    // only the second stage of each pair feeds any logic
    logic [1:0] irq_sync_q;
    logic [1:0] rtc_sync_q;
    logic [1:0] rirq_sync_q;
    logic [1:0] idle_sync_q;
    logic [1:0] byp_sync_q;
    logic [1:0] df_sync_q;
    logic [4:0] msel_s1_q;
    logic [4:0] msel_s2_q;
    logic [1:0] ssel_s1_q;
    logic [1:0] ssel_s2_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_sync_q <= 2'h0;
            rtc_sync_q <= 2'h0;
            rirq_sync_q <= 2'h0;
            idle_sync_q <= 2'h0;
        end else begin
            irq_sync_q <= {irq_sync_q[0], irq_any_i};
            rtc_sync_q <= {rtc_sync_q[0], rtc_irq_i};
            rirq_sync_q <= {rirq_sync_q[0], reset_irq_i};
            idle_sync_q <= {idle_sync_q[0], core_idle_i};
        end
    end

    // straps keep sampling through reset so they are settled at release
    always_ff @(posedge core_clk_i) begin
        byp_sync_q <= {byp_sync_q[0], bypass_strap_i};
        df_sync_q <= {df_sync_q[0], input_divide_strap_i};
        msel_s1_q <= multiplier_select_straps_i;
        msel_s2_q <= msel_s1_q;
        ssel_s1_q <= ssel_straps_i;
        ssel_s2_q <= ssel_s1_q;
    end

    logic irq_s;
    logic rtc_s;
    logic rirq_s;
    logic idle_s;
    assign irq_s = irq_sync_q[1];
    assign rtc_s = rtc_sync_q[1];
    assign rirq_s = rirq_sync_q[1];
    assign idle_s = idle_sync_q[1];

    // ==================================================
    // strap capture just after reset release
    logic strap_load_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            strap_load_q <= 1'b1;
        end else begin
            strap_load_q <= 1'b0;
        end
    end

    // ==================================================
    // pll control register
    logic [4:0] msel_q;
    logic df_q;
    logic bypass_q;
    logic [1:0] ssel_q;
    logic req_sleep_q;
    logic req_deep_q;
    logic go_q;
    pmcc_mode_e mode_q;
    pmcc_mode_e mode_d;

    logic wr_ctl;
    logic wr_en;
    assign wr_ctl = avs_write_i && (avs_address_i == PMCC_PLL_CONTROL_REG_OFS);
    assign wr_en = avs_write_i && (avs_address_i == PMCC_PERIPH_EN_OFS);

    function automatic logic [4:0] clip_msel(input logic [4:0] v);
        // zero is out of range and is taken as the lowest ratio
        clip_msel = (v < PMCC_MSEL_MIN) ? PMCC_MSEL_MIN : v;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            msel_q <= PMCC_MSEL_MIN;
            df_q <= 1'b0;
            bypass_q <= 1'b0;
            ssel_q <= PMCC_SSEL_2;
        end else if (strap_load_q) begin
            msel_q <= clip_msel(msel_s2_q);
            df_q <= df_sync_q[1];
            bypass_q <= byp_sync_q[1];
            ssel_q <= ssel_s2_q;
        end else if (wr_ctl) begin
            // multiplier is only retuned with the PLL out of the path
            if (mode_q == PMCC_ACTIVE) begin
                msel_q <= clip_msel(
                    avs_writedata_i[PMCC_MSEL_LSB +: PMCC_MSEL_W]);
                df_q <= avs_writedata_i[PMCC_DF_BIT];
            end
            // bypass and divide select may be rewritten in any mode
            bypass_q <= avs_writedata_i[PMCC_BYPASS_BIT];
            ssel_q <= avs_writedata_i[PMCC_SSEL_LSB +: PMCC_SSEL_W];
        end
    end

    // pending mode request, executed once the core reports idle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            go_q <= 1'b0;
            req_sleep_q <= 1'b0;
            req_deep_q <= 1'b0;
        end else if (wr_ctl && avs_writedata_i[PMCC_GO_BIT]) begin
            go_q <= 1'b1;
            req_sleep_q <= avs_writedata_i[PMCC_SLEEP_BIT];
            req_deep_q <= avs_writedata_i[PMCC_DEEP_BIT];
        end else if (go_q && idle_s) begin
            go_q <= 1'b0;
        end
    end

    // ==================================================
    // peripheral clock enables
    logic [13:0] periph_en_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            periph_en_q <= PMCC_PERIPH_EN_RST;
        end else if (wr_en) begin
            periph_en_q <= avs_writedata_i[PMCC_NUM_PERIPH-1:0];
        end
    end

    // ==================================================
    // mode state machine

    // run mode picked by a bypass level: pll path or reference path
    function automatic pmcc_mode_e run_mode(input logic byp);
        run_mode = byp ? PMCC_ACTIVE : PMCC_FULL_ON;
    endfunction

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PMCC_FULL_ON, PMCC_ACTIVE: begin
                if (go_q && idle_s) begin
                    if (req_deep_q) begin
                        mode_d = PMCC_DEEP_SLEEP;
                    end else if (req_sleep_q) begin
                        mode_d = PMCC_SLEEP;
                    end else begin
                        mode_d = run_mode(bypass_q);
                    end
                end
            end
            PMCC_SLEEP: begin
                if (irq_s || rtc_s || rirq_s) begin
                    mode_d = run_mode(bypass_q);
                end
            end
            PMCC_DEEP_SLEEP: begin
                // ordinary interrupts are not looked at here; the reset
                // interrupt wins when it arrives with the rtc one
                if (rirq_s) begin
                    mode_d = run_mode(byp_sync_q[1]);
                end else if (rtc_s) begin
                    mode_d = PMCC_FULL_ON;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_q <= PMCC_FULL_ON;
        end else if (strap_load_q) begin
            mode_q <= run_mode(byp_sync_q[1]);
        end else begin
            mode_q <= mode_d;
        end
    end

    // ==================================================
    // clock enable generation
    logic half_tick;
    logic sclk_tick;
    logic core_run;
    logic sys_run;
    logic bypassed;

    assign bypassed = (mode_q == PMCC_ACTIVE) ||
                      ((mode_q == PMCC_SLEEP) && bypass_q);
    assign core_run = (mode_q == PMCC_FULL_ON) ||
                      (mode_q == PMCC_ACTIVE);
    assign sys_run = (mode_q != PMCC_DEEP_SLEEP);

    pmcc_half_div u_half (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(bypassed),
        .tick_o(half_tick)
    );

    logic core_clock_tick;
    // pll path: full rate tick; bypass: half the reference rate
    assign core_clock_tick = bypassed ? half_tick : 1'b1;

    pmcc_sclk_div u_sdiv (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .core_clock_tick_i(core_clock_tick),
        .run_i(sys_run),
        .ssel_i(ssel_q),
        .sclk_tick_o(sclk_tick)
    );

    // one gate per peripheral, so each clock can be stopped on its own
    wire [13:0] periph_gate;
    for (genvar g = 0; g < PMCC_NUM_PERIPH; g++) begin : g_gate
        assign periph_gate[g] = sclk_tick & periph_en_q[g];
    end

    // ==================================================
    // registered outputs
    // enables leave on flops so the gated clocks see clean levels
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            core_clock_en_o <= 1'b0;
            system_clock_output_pin_o <= 1'b0;
            periph_clk_en_o <= 14'h0000;
        end else begin
            core_clock_en_o <= core_run & core_clock_tick;
            system_clock_output_pin_o <= sclk_tick;
            periph_clk_en_o <= periph_gate;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pll_enable_o <= 1'b0;
            pll_bypass_o <= 1'b0;
            pll_mult_o <= PMCC_MSEL_MIN;
            pll_input_div_o <= 1'b0;
            dma_l1_allow_o <= 1'b0;
            deep_sleep_indicator_o <= 1'b0;
            mode_o <= 2'h0;
        end else begin
            pll_enable_o <= (mode_q != PMCC_DEEP_SLEEP);
            pll_bypass_o <= bypassed;
            pll_mult_o <= msel_q;
            pll_input_div_o <= df_q;
            dma_l1_allow_o <= (mode_q == PMCC_ACTIVE);
            deep_sleep_indicator_o <= (mode_q == PMCC_DEEP_SLEEP);
            mode_o <= mode_q;
        end
    end

    // ==================================================
    // avalon read path: zero wait states, unmapped reads give zero
    always_comb begin
        avs_readdata_o = 32'h0000_0000;
        unique case (avs_address_i)
            PMCC_PLL_CONTROL_REG_OFS: begin
                avs_readdata_o[PMCC_MSEL_LSB +: PMCC_MSEL_W] = msel_q;
                avs_readdata_o[PMCC_DF_BIT] = df_q;
                avs_readdata_o[PMCC_BYPASS_BIT] = bypass_q;
                avs_readdata_o[PMCC_SSEL_LSB +: PMCC_SSEL_W] = ssel_q;
                avs_readdata_o[PMCC_GO_BIT] = go_q;
                avs_readdata_o[PMCC_SLEEP_BIT] = req_sleep_q;
                avs_readdata_o[PMCC_DEEP_BIT] = req_deep_q;
            end
            PMCC_PERIPH_EN_OFS: begin
                avs_readdata_o[PMCC_NUM_PERIPH-1:0] = periph_en_q;
            end
            PMCC_STATUS_OFS: begin
                avs_readdata_o[1:0] = mode_q;
            end
            default: begin
                avs_readdata_o = 32'h0000_0000;
            end
        endcase
    end

    assign avs_waitrequest_o = 1'b0;

endmodule

//--- test/pmcc_props.sv
// checker for mode, clock enable and wake rules of the mode controller
module pmcc_props
    import pmcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // straps and events
    input wire logic bypass_strap_i,
    input wire logic rtc_irq_i,
    input wire logic reset_irq_i,
    // clock enables and status
    input wire logic core_clock_en_o,
    input wire logic system_clock_output_pin_o,
    input wire logic [13:0] periph_clk_en_o,
    input wire logic pll_enable_o,
    input wire logic pll_bypass_o,
    input wire logic dma_l1_allow_o,
    input wire logic deep_sleep_indicator_o,
    input wire logic [1:0] mode_o
);
    // ========
    // assertions
    // outputs lag mode by one edge, so the per-mode checks wait for a settled mode
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_FULL_ON: assert property (
        (mode_o == PMCC_FULL_ON)[*4] |->
        pll_enable_o && !pll_bypass_o && core_clock_en_o)
        else $error("full on clocking wrong");
    AST_HALF_RATE: assert property (
        (mode_o == PMCC_ACTIVE)[*5] |->
        pll_bypass_o && core_clock_en_o != $past(core_clock_en_o))
        else $error("active core clock not half rate");
    AST_DMA: assert property (
        $stable(mode_o)[*2] |-> dma_l1_allow_o == (mode_o == PMCC_ACTIVE))
        else $error("dma permission wrong");
    AST_SLEEP: assert property (
        (mode_o == PMCC_SLEEP)[*4] |-> !core_clock_en_o && pll_enable_o)
        else $error("sleep clocking wrong");
    AST_SLEEP_WAKE: assert property (
        (mode_o == PMCC_SLEEP) ##1 (mode_o != PMCC_SLEEP) |->
        mode_o == ($past(pll_bypass_o) ? PMCC_ACTIVE : PMCC_FULL_ON))
        else $error("sleep woke to wrong mode");
    AST_DEEP: assert property (
        (mode_o == PMCC_DEEP_SLEEP)[*4] |-> !core_clock_en_o &&
        !system_clock_output_pin_o && !pll_enable_o && periph_clk_en_o == 0)
        else $error("deep sleep clocks running");
    AST_DEEP_EXIT: assert property (
        (mode_o == PMCC_DEEP_SLEEP) ##1 (mode_o != PMCC_DEEP_SLEEP) |->
        $past(rtc_irq_i, 3) || $past(reset_irq_i, 3))
        else $error("deep sleep left without wake event");
    AST_DEEP_WAKE: assert property (
        (mode_o == PMCC_DEEP_SLEEP) ##1 (mode_o != PMCC_DEEP_SLEEP) |->
        mode_o == (($past(reset_irq_i, 3) && bypass_strap_i) ?
        PMCC_ACTIVE : PMCC_FULL_ON))
        else $error("deep sleep woke to wrong mode");
    AST_DEEP_FLAG: assert property (
        $stable(mode_o)[*2] |->
        deep_sleep_indicator_o == (mode_o == PMCC_DEEP_SLEEP))
        else $error("deep sleep indicator wrong");
    AST_PERIPH: assert property (
        |periph_clk_en_o |-> system_clock_output_pin_o)
        else $error("peripheral tick without system tick");
    // ========
    // coverage
    COV_SLEEP: cover property (mode_o == PMCC_SLEEP);
    COV_DEEP: cover property (mode_o == PMCC_DEEP_SLEEP);
    COV_ACTIVE: cover property (mode_o == PMCC_ACTIVE);
    COV_RTC: cover property ((mode_o == PMCC_DEEP_SLEEP) ##1
        (mode_o == PMCC_FULL_ON));
endmodule

bind pmcc_top pmcc_props u_props (.*);

//--- test/pmcc_core_model.sv
// core side model: reaches idle some cycles after running the sequence
module pmcc_core_model
    import pmcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // software control
    input wire logic seq_start_i,
    input wire logic [3:0] idle_delay_i,
    // idle out
    output logic core_idle_o
);
    logic [3:0] cnt_q;
    // software has quiesced dma before it starts the sequence
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !seq_start_i) begin
            cnt_q <= 4'h0;
            core_idle_o <= 1'b0;
        end else if (cnt_q == idle_delay_i) begin
            core_idle_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

//--- test/pmcc_tb_top.sv
// testbench for the power mode clock control
module pmcc_tb_top
    import pmcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // signals
    logic clk = 0, rst = 1, rd = 0, wr = 0, wt, irq = 0, rtc = 0, rirq = 0;
    logic seq = 0, bs = 0, idle, cen, sclk, pll_en, byp, idiv, dma, dsi;
    logic [3:0] adr = 4'h0, dly = 4'h0;
    logic [31:0] wd = 32'h0, rdata, q;
    logic [13:0] pen, pe;
    logic [4:0] mult;
    logic [1:0] mode;
    int bad_count = 0, samples_checked = 0, cycles = 0, c;
    int exp_cnt[4] = '{30, 24, 20, 15};
    always #5 clk = ~clk;
    pmcc_top DUT (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .multiplier_select_straps_i(5'h06), .bypass_strap_i(bs),
        .input_divide_strap_i(1'b1), .ssel_straps_i(2'h2),
        .irq_any_i(irq), .rtc_irq_i(rtc), .reset_irq_i(rirq),
        .core_idle_i(idle), .core_clock_en_o(cen),
        .system_clock_output_pin_o(sclk), .periph_clk_en_o(pen),
        .pll_enable_o(pll_en), .pll_bypass_o(byp), .pll_mult_o(mult),
        .pll_input_div_o(idiv), .dma_l1_allow_o(dma),
        .deep_sleep_indicator_o(dsi), .mode_o(mode));
    pmcc_core_model u_core (.core_clk_i(clk), .rst_i(rst),
        .seq_start_i(seq), .idle_delay_i(dly), .core_idle_o(idle));
    // ========
    // tasks
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(logic [4:0] m, logic b,
        logic [1:0] s, logic [2:0] op);
        return {17'h0, op, 2'h0, s, 1'b0, b, 1'b0, m};
    endfunction
    task automatic wait_mode(input pmcc_mode_e m);
        int n;
        n = 0;
        while (mode !== m && n < 80) begin
            @(negedge clk);
            n++;
        end
        check("mode", mode, m);
        repeat (2) @(posedge clk);
    endtask
    task automatic go(input logic [31:0] w, input pmcc_mode_e m);
        bus(1'b1, PMCC_PLL_CONTROL_REG_OFS, w);
        seq <= 1'b1;
        wait_mode(m);
        seq <= 1'b0;
    endtask
    task automatic count(input int n);
        c = 0;
        pe = 14'h0;
        repeat (n) begin
            @(negedge clk);
            c += sclk;
            pe |= pen;
        end
        @(posedge clk);
    endtask
    // ========
    // timeout
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ========
    // tests
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        check("mode", mode, PMCC_FULL_ON);
        check("mult", mult, 5'h06);
        check("idiv", idiv, 1'b1);
        check("pll", pll_en, 1'b1);
        check("bypass", byp, 1'b0);
        bus(1'b0, PMCC_PLL_CONTROL_REG_OFS, 32'h0);
        check("ssel", q[9:8], 2'h2);
        bus(1'b0, PMCC_PERIPH_EN_OFS, 32'h0);
        check("periph", q, 32'h3FFF);
        bus(1'b0, 4'hC, 32'h0);
        check("unmapped", q, 32'h0);
        // multiplier is locked while the pll is in use
        bus(1'b1, PMCC_PLL_CONTROL_REG_OFS, ctl(5'h09, 1'b0, 2'h0, 3'h0));
        repeat (4) @(posedge clk);
        check("mult", mult, 5'h06);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, PMCC_PLL_CONTROL_REG_OFS,
                ctl(5'h06, 1'b0, s[1:0], 3'h0));
            repeat (8) @(posedge clk);
            count(60);
            check("sclk ticks", c, exp_cnt[s]);
        end
        for (int i = 0; i < 14; i++) begin
            bus(1'b1, PMCC_PERIPH_EN_OFS, 32'h1 << i);
            repeat (4) @(posedge clk);
            count(16);
            check("periph", pe, 14'h1 << i);
            check("sclk out", c, 4);
        end
        bus(1'b1, PMCC_PERIPH_EN_OFS, 32'h3FFF);
        // slow core: sleep, any interrupt wakes to full on
        dly <= 4'h9;
        go(ctl(5'h06, 1'b0, 2'h0, 3'h3), PMCC_SLEEP);
        count(12);
        check("sclk in sleep", c > 0, 1'b1);
        irq <= 1'b1;
        wait_mode(PMCC_FULL_ON);
        irq <= 1'b0;
        // prompt core: into active, multiplier now accepted
        dly <= 4'h0;
        go(ctl(5'h06, 1'b1, 2'h0, 3'h1), PMCC_ACTIVE);
        check("dma", dma, 1'b1);
        check("bypass", byp, 1'b1);
        bus(1'b0, PMCC_STATUS_OFS, 32'h0);
        check("status", q, PMCC_ACTIVE);
        bus(1'b1, PMCC_PLL_CONTROL_REG_OFS, ctl(5'h1F, 1'b1, 2'h0, 3'h0));
        repeat (2) @(posedge clk);
        check("mult", mult, 5'h1F);
        check("idiv", idiv, 1'b0);
        bus(1'b1, PMCC_PLL_CONTROL_REG_OFS, ctl(5'h00, 1'b1, 2'h0, 3'h0));
        repeat (2) @(posedge clk);
        check("mult", mult, 5'h01);
        go(ctl(5'h01, 1'b1, 2'h0, 3'h3), PMCC_SLEEP);
        check("dma", dma, 1'b0);
        rtc <= 1'b1;
        wait_mode(PMCC_ACTIVE);
        rtc <= 1'b0;
        // deep sleep ignores ordinary interrupts
        go(ctl(5'h01, 1'b1, 2'h0, 3'h5), PMCC_DEEP_SLEEP);
        check("deep flag", dsi, 1'b1);
        check("pll", pll_en, 1'b0);
        irq <= 1'b1;
        repeat (20) @(posedge clk);
        check("mode", mode, PMCC_DEEP_SLEEP);
        irq <= 1'b0;
        rtc <= 1'b1;
        wait_mode(PMCC_FULL_ON);
        rtc <= 1'b0;
        check("deep flag", dsi, 1'b0);
        go(ctl(5'h01, 1'b0, 2'h0, 3'h5), PMCC_DEEP_SLEEP);
        rirq <= 1'b1;
        wait_mode(PMCC_FULL_ON);
        rirq <= 1'b0;
        // reset interrupt with the bypass strap up lands in active
        go(ctl(5'h01, 1'b0, 2'h0, 3'h5), PMCC_DEEP_SLEEP);
        bs <= 1'b1;
        rirq <= 1'b1;
        wait_mode(PMCC_ACTIVE);
        rirq <= 1'b0;
        // reset in mid-run: the straps now ask for active
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        check("mode", mode, PMCC_ACTIVE);
        check("bypass", byp, 1'b1);
        print_verdict();
    end
endmodule
